//--- inc/flash_guard_pkg.sv
// types for the flash write guard
package flash_guard_pkg;
	typedef enum logic [2:0] {
		ST_READ, ST_UNLOCK2, ST_COMMAND, ST_PROG_DATA,
		ST_ERASE_UNLOCK1, ST_ERASE_UNLOCK2, ST_ERASE_CMD
	} seq_state_type;
	typedef enum logic [1:0] {OP_IDLE, OP_PROGRAM, OP_PREPROG, OP_ERASE} op_state_type;
endpackage

//--- inc/flash_guard_regs.svh
// timing constants and field values for the write guard
`ifndef FLASH_GUARD_REGS_SVH
`define FLASH_GUARD_REGS_SVH
`define CLK_PERIOD_PS      25000
`define GLITCH_TIME_PS     5000
`define GLITCH_CYCLES      ((`GLITCH_TIME_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define ERS_TIME_US        400
`define ERS_CYCLES         (`ERS_TIME_US * 40)
`define PRS_TIME_US        25
`define PRS_CYCLES         (`PRS_TIME_US * 40)
`define UNLOCK_ADDR_BITS   16
`define UNLOCK1_ADDR       16'h0555
`define UNLOCK2_ADDR       16'h02AA
`define UNLOCK1_DATA       16'h00AA
`define UNLOCK2_DATA       16'h0055
`define CMD_PROGRAM        16'h00A0
`define CMD_ERASE_SETUP    16'h0080
`define CMD_SECTOR_ERASE   16'h0030
`define PREPROGRAM_DATA    16'h0000
`define ERASED_DATA        16'hFFFF
`define POLL_BIT           7
`define TOGGLE_BIT         6
`define TOGGLE2_BIT        2
`endif

//--- rtl/flash_write_guard.sv
// write qualification, lockout and status polling for the flash
`timescale 1ns/1ps
`include "flash_guard_regs.svh"
// Operation
// - write needs select, strobe low, enable high
// - strobe pulses under 5ns are ignored
// - power-up state is read mode
// - only complete command sequences start operations
// - strobes held low at power-up drop first command
// - low supply resets and blocks writes
// - status reads answered through the clocked rdata_out register
// - finished operation returns true data
// - toggle bits flip per read while busy
// - unlock cycles decode only low address bits
// - erase preprograms target to zero first
module flash_write_guard
	import flash_guard_pkg::*;
#(
	parameter int OP_CYCLES = 64
) (
	input  wire logic        core_clk_in,
	input  wire logic        rst_n_in,
	input  wire logic        chip_sel_n_in,
	input  wire logic        write_n_in,
	input  wire logic        out_en_n_in,
	input  wire logic        supply_low_in,
	input  wire logic [22:0] addr_in,
	input  wire logic [15:0] wdata_in,
	input  wire logic [15:0] array_data_in,
	output logic      [15:0] rdata_out,
	output logic             busy_out,
	output logic             array_we_out,
	output logic      [22:0] array_addr_out,
	output logic      [15:0] array_wdata_out
);
	localparam int GW = `GLITCH_CYCLES;
	localparam int CW = $clog2(OP_CYCLES + 1);

	seq_state_type    seq;
	op_state_type     op;
	logic [7:0]       low_count;
	logic             strobe_prev;
	logic             qualified;
	logic             write_event;
	logic             powerup_hold;
	logic             powerup_seen;
	logic             read_prev;
	logic             toggle;
	logic [15:0]      poll_data;
	logic [22:0]      op_addr;
	logic [CW-1:0]    op_count;
	logic [15:0]      low_addr;
	logic             read_cycle;
	logic [15:0]      status_word;

	////////////////////////////////////////////////////////////
	assign qualified  = !chip_sel_n_in && !write_n_in && out_en_n_in;
	assign low_addr   = addr_in[`UNLOCK_ADDR_BITS-1:0];
	assign read_cycle = !chip_sel_n_in && !out_en_n_in && write_n_in;

	// count cycles the qualifying combination has been held
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			low_count   <= 8'h00;
			strobe_prev <= 1'b0;
		end else begin
			strobe_prev <= qualified;
			if (!qualified)
				low_count <= 8'h00;
			else if (low_count != 8'hFF)
				low_count <= low_count + 8'h01;
		end
	end

	// write on strobe release, held past the glitch window: one sample may be a glitch
	assign write_event = strobe_prev && write_n_in && !chip_sel_n_in && out_en_n_in
		&& (low_count > 8'(GW)) && !supply_low_in;

	////////////////////////////////////////////////////////////
	// strobes held low out of reset: discard first command
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			powerup_seen <= 1'b0;
			powerup_hold <= 1'b0;
		end else begin
			powerup_seen <= 1'b1;
			if (!powerup_seen && qualified)
				powerup_hold <= 1'b1;
			else if (write_event)
				powerup_hold <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////
	// command sequence decoder
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			seq <= ST_READ;
		end else if (supply_low_in) begin
			seq <= ST_READ;
		end else if (write_event && !powerup_hold && !busy_out) begin
			case (seq)
				ST_READ:
					seq <= (low_addr == `UNLOCK1_ADDR && wdata_in == `UNLOCK1_DATA) ? ST_UNLOCK2 : ST_READ;
				ST_UNLOCK2:
					seq <= (low_addr == `UNLOCK2_ADDR && wdata_in == `UNLOCK2_DATA) ? ST_COMMAND : ST_READ;
				ST_COMMAND: begin
					if (low_addr == `UNLOCK1_ADDR && wdata_in == `CMD_PROGRAM)
						seq <= ST_PROG_DATA;
					else if (low_addr == `UNLOCK1_ADDR && wdata_in == `CMD_ERASE_SETUP)
						seq <= ST_ERASE_UNLOCK1;
					else
						seq <= ST_READ;
				end
				ST_ERASE_UNLOCK1:
					seq <= (low_addr == `UNLOCK1_ADDR && wdata_in == `UNLOCK1_DATA) ? ST_ERASE_UNLOCK2 : ST_READ;
				ST_ERASE_UNLOCK2:
					seq <= (low_addr == `UNLOCK2_ADDR && wdata_in == `UNLOCK2_DATA) ? ST_ERASE_CMD : ST_READ;
				default:
					seq <= ST_READ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////
	// embedded operation engine
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			op        <= OP_IDLE;
			op_count  <= '0;
			op_addr   <= 23'h000000;
			poll_data <= 16'h0000;
		end else if (supply_low_in) begin
			op       <= OP_IDLE;
			op_count <= '0;
		end else begin
			case (op)
				OP_IDLE: begin
					if (write_event && !powerup_hold && seq == ST_PROG_DATA) begin
						op        <= OP_PROGRAM;
						op_addr   <= addr_in;
						poll_data <= wdata_in;
						op_count  <= CW'(OP_CYCLES);
					end else if (write_event && !powerup_hold && seq == ST_ERASE_CMD
						&& wdata_in == `CMD_SECTOR_ERASE) begin
						op        <= OP_PREPROG;
						op_addr   <= addr_in;
						poll_data <= `PREPROGRAM_DATA;
						op_count  <= CW'(OP_CYCLES);
					end
				end
				OP_PREPROG: begin
					if (op_count == '0) begin
						op        <= OP_ERASE;
						poll_data <= `ERASED_DATA;
						op_count  <= CW'(OP_CYCLES);
					end else
						op_count <= op_count - CW'(1);
				end
				OP_PROGRAM, OP_ERASE: begin
					if (op_count == '0)
						op <= OP_IDLE;
					else
						op_count <= op_count - CW'(1);
				end
				default:
					op <= OP_IDLE;
			endcase
		end
	end

	// stays up until the final word is committed
	assign busy_out = (op != OP_IDLE) || array_we_out;

	// array write port: one pulse per programmed word
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			array_we_out    <= 1'b0;
			array_addr_out  <= 23'h000000;
			array_wdata_out <= 16'h0000;
		end else begin
			array_we_out    <= (op != OP_IDLE) && op_count == '0 && !supply_low_in;
			array_addr_out  <= op_addr;
			array_wdata_out <= poll_data;
		end
	end

	////////////////////////////////////////////////////////////
	// clocked status reads, toggle per read start
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			read_prev <= 1'b0;
			toggle    <= 1'b0;
		end else begin
			read_prev <= read_cycle;
			if (read_cycle && !read_prev && busy_out)
				toggle <= ~toggle;
		end
	end

	always_comb begin
		status_word               = 16'h0000;
		status_word[`POLL_BIT]    = ~poll_data[`POLL_BIT];
		status_word[`TOGGLE_BIT]  = toggle;
		status_word[`TOGGLE2_BIT] = toggle;
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rdata_out <= 16'h0000;
		end else if (busy_out) begin
			rdata_out <= status_word;
		end else begin
			rdata_out <= array_data_in;
		end
	end

	////////////////////////////////////////////////////////////
	property p_glitch_no_write;
		@(posedge core_clk_in) disable iff (!rst_n_in)
		(strobe_prev && low_count <= 8'(GW)) |-> !write_event;
	endproperty
	a_glitch_no_write: assert property (p_glitch_no_write) else $error("short strobe accepted");

	property p_logic_prohibit;
		@(posedge core_clk_in) disable iff (!rst_n_in)
		write_event |-> (!chip_sel_n_in && out_en_n_in && $past(qualified));
	endproperty
	a_logic_prohibit: assert property (p_logic_prohibit) else $error("write without qualifying pins");

	property p_lockout;
		@(posedge core_clk_in) disable iff (!rst_n_in)
		supply_low_in |=> (seq == ST_READ && op == OP_IDLE);
	endproperty
	a_lockout: assert property (p_lockout) else $error("state survived low supply");

	property p_powerup_discard;
		@(posedge core_clk_in) disable iff (!rst_n_in)
		(write_event && powerup_hold && op == OP_IDLE) |=> (seq == $past(seq) && op == OP_IDLE);
	endproperty
	a_powerup_discard: assert property (p_powerup_discard) else $error("first command not discarded");

	property p_start_needs_seq;
		@(posedge core_clk_in) disable iff (!rst_n_in)
		($rose(busy_out)) |-> ($past(seq) == ST_PROG_DATA || $past(seq) == ST_ERASE_CMD);
	endproperty
	a_start_needs_seq: assert property (p_start_needs_seq) else $error("operation without sequence");

	property p_true_data;
		@(posedge core_clk_in) disable iff (!rst_n_in)
		!busy_out ##1 !busy_out |-> rdata_out == $past(array_data_in);
	endproperty
	a_true_data: assert property (p_true_data) else $error("idle read not true data");

	property p_toggle_flip;
		@(posedge core_clk_in) disable iff (!rst_n_in)
		(read_cycle && !read_prev && busy_out && !supply_low_in) |=> toggle != $past(toggle);
	endproperty
	a_toggle_flip: assert property (p_toggle_flip) else $error("toggle bit did not flip");

	property p_toggle_steady;
		@(posedge core_clk_in) disable iff (!rst_n_in)
		!busy_out |=> $stable(toggle);
	endproperty
	a_toggle_steady: assert property (p_toggle_steady) else $error("toggle moved while idle");

	property p_poll_complement;
		@(posedge core_clk_in) disable iff (!rst_n_in)
		busy_out |=> rdata_out[`POLL_BIT] == ~$past(poll_data[`POLL_BIT]);
	endproperty
	a_poll_complement: assert property (p_poll_complement) else $error("poll bit not complement");

	property p_preprog_first;
		@(posedge core_clk_in) disable iff (!rst_n_in)
		(op == OP_IDLE ##1 op == OP_PREPROG) |-> poll_data == `PREPROGRAM_DATA;
	endproperty
	a_preprog_first: assert property (p_preprog_first) else $error("erase without preprogram");

	c_program: cover property (@(posedge core_clk_in) disable iff (!rst_n_in) op == OP_IDLE ##1 op == OP_PROGRAM);
	c_erase: cover property (@(posedge core_clk_in) disable iff (!rst_n_in) op == OP_PREPROG ##1 op == OP_ERASE);
	c_lockout: cover property (@(posedge core_clk_in) disable iff (!rst_n_in) busy_out ##1 supply_low_in);
	c_toggle: cover property (@(posedge core_clk_in) disable iff (!rst_n_in) busy_out && $changed(toggle));
endmodule

//--- sim/flash_host_model.sv
// host bus model with the word array behind the guard
`timescale 1ns/1ps
module flash_host_model (
	input  wire logic        clk_in,
	input  wire logic        array_we_in,
	input  wire logic [22:0] array_addr_in,
	input  wire logic [15:0] array_wdata_in,
	input  wire logic [15:0] rdata_in,
	output logic             chip_sel_n_out,
	output logic             write_n_out,
	output logic             out_en_n_out,
	output logic      [22:0] addr_out,
	output logic      [15:0] wdata_out,
	output logic      [15:0] array_data_out
);
	logic [15:0] mem [16];
	// model never issues suspend, so no resume-to-suspend gap arises
	assign array_data_out = mem[addr_out[3:0]];
	initial begin
		foreach (mem[i]) mem[i] = 16'hFFFF;
		chip_sel_n_out = 1'b1;
		write_n_out = 1'b1;
		out_en_n_out = 1'b1;
		addr_out = 23'h0;
		wdata_out = 16'h0;
	end
	always @(posedge clk_in) begin
		if (array_we_in) begin
			mem[array_addr_in[3:0]] <= array_wdata_in;
		end
	end
	task automatic wr(input logic [22:0] a, input logic [15:0] d, input logic oe_n);
		@(negedge clk_in);
		addr_out = a;
		wdata_out = d;
		chip_sel_n_out = 1'b0;
		write_n_out = 1'b0;
		out_en_n_out = oe_n;
		repeat (2) @(negedge clk_in);
		write_n_out = 1'b1;
		@(negedge clk_in);
		chip_sel_n_out = 1'b1;
		out_en_n_out = 1'b1;
		wdata_out = ~d;
	endtask
	task automatic rd(input logic [22:0] a, output logic [15:0] q);
		@(negedge clk_in);
		addr_out = a;
		chip_sel_n_out = 1'b0;
		out_en_n_out = 1'b0;
		repeat (2) @(negedge clk_in);
		q = rdata_in;
		chip_sel_n_out = 1'b1;
		out_en_n_out = 1'b1;
	endtask
	// 2ns strobe pulse straddling one rising edge, select held low
	task automatic glitch;
		@(negedge clk_in);
		chip_sel_n_out = 1'b0;
		#11.5;
		write_n_out = 1'b0;
		#2;
		write_n_out = 1'b1;
		repeat (2) @(negedge clk_in);
		chip_sel_n_out = 1'b1;
	endtask
	task automatic hold;
		chip_sel_n_out = 1'b0;
		write_n_out = 1'b0;
	endtask
endmodule

//--- sim/test_flash_write_guard.sv
// self-checking bench for the flash write guard
`timescale 1ns/1ps
`include "flash_guard_regs.svh"
module test_flash_write_guard;
	typedef struct {logic [22:0] hi; logic [22:0] a; logic [15:0] d;} row_type;
	row_type     rows [3] = '{'{23'h0, 23'h3, 16'h5A5A}, '{23'h7F0000, 23'h9, 16'hC3A5},
	                          '{23'h010000, 23'h6, 16'h8081}};
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        low = 1'b0;
	logic        cs_n, we_n, oe_n, busy, awe;
	logic [22:0] addr, aaddr, last_a;
	logic [15:0] wdata, adata, rdata, awdata, last_d, q1, q2;
	logic        seen0 = 1'b0;
	int          n_fail = 0;
	int          n_checks = 0;
	int          n_we = 0;
	int          w0 = 0;
	flash_write_guard #(.OP_CYCLES(12)) i_dut (
		.core_clk_in(clk), .rst_n_in(rst_n), .chip_sel_n_in(cs_n), .write_n_in(we_n),
		.out_en_n_in(oe_n), .supply_low_in(low), .addr_in(addr), .wdata_in(wdata),
		.array_data_in(adata), .rdata_out(rdata), .busy_out(busy), .array_we_out(awe),
		.array_addr_out(aaddr), .array_wdata_out(awdata));
	flash_host_model i_host (
		.clk_in(clk), .array_we_in(awe), .array_addr_in(aaddr), .array_wdata_in(awdata),
		.rdata_in(rdata), .chip_sel_n_out(cs_n), .write_n_out(we_n), .out_en_n_out(oe_n),
		.addr_out(addr), .wdata_out(wdata), .array_data_out(adata));
	initial begin
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) begin
		if (awe === 1'b1) begin
			n_we++;
			last_a = aaddr;
			last_d = awdata;
			if (awdata === 16'h0000) seen0 = 1'b1;
		end
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic prog(input logic [22:0] hi, a, input logic [15:0] d, c, input logic oe);
		w0 = n_we;
		i_host.wr(hi | 23'(`UNLOCK1_ADDR), `UNLOCK1_DATA, 1'b1);
		i_host.wr(hi | 23'(`UNLOCK2_ADDR), `UNLOCK2_DATA, 1'b1);
		i_host.wr(hi | 23'(`UNLOCK1_ADDR), c, oe);
		i_host.wr(a, d, 1'b1);
	endtask
	task automatic idle;
		for (int k = 0; k < 200 && busy !== 1'b0; k++) @(negedge clk);
		chk({15'h0, busy}, 16'h0000);
	endtask
	task automatic none;
		repeat (4) @(negedge clk);
		chk({15'h0, busy}, 16'h0000);
		chk(16'(n_we - w0), 16'h0000);
	endtask
	task automatic finish_test;
		$display("checks %0d failures %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	initial begin
		#200000;
		n_fail++;
		finish_test();
	end
	initial begin
		repeat (10) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		chk({15'h0, busy}, 16'h0000);
		i_host.rd(23'h3, q1);
		chk(q1, 16'hFFFF);
		$display("reset test done");
		foreach (rows[i]) begin
			prog(rows[i].hi, rows[i].a, rows[i].d, `CMD_PROGRAM, 1'b1);
			i_host.rd(rows[i].a, q1);
			i_host.rd(rows[i].a, q2);
			chk({15'h0, busy}, 16'h0001);
			chk(q1 & 16'h0080, ~rows[i].d & 16'h0080);
			chk((q1 ^ q2) & 16'h0044, 16'h0044);
			idle();
			chk(last_d, rows[i].d);
			chk(last_a[15:0], rows[i].a[15:0]);
			i_host.rd(rows[i].a, q1);
			i_host.rd(rows[i].a, q2);
			chk(q1, rows[i].d);
			chk(q1 ^ q2, 16'h0000);
		end
		$display("program rows done");
		prog(23'h0, 23'(`UNLOCK1_ADDR), `UNLOCK1_DATA, `CMD_ERASE_SETUP, 1'b1);
		i_host.wr(23'(`UNLOCK2_ADDR), `UNLOCK2_DATA, 1'b1);
		i_host.wr(23'h9, `CMD_SECTOR_ERASE, 1'b1);
		idle();
		chk({15'h0, seen0}, 16'h0001);
		chk(16'(n_we - w0), 16'h0002);
		i_host.rd(23'h9, q1);
		chk(q1, `ERASED_DATA);
		$display("erase test done");
		prog(23'h0, 23'h3, 16'h1111, `CMD_PROGRAM, 1'b0);
		none();
		prog(23'h0, 23'h3, 16'h1111, 16'h0077, 1'b1);
		none();
		prog(23'h0, 23'h3, 16'h1111, `CMD_PROGRAM, 1'b1);
		repeat (2) @(negedge clk);
		low = 1'b1;
		none();
		prog(23'h0, 23'h3, 16'h1111, `CMD_PROGRAM, 1'b1);
		none();
		low = 1'b0;
		w0 = n_we;
		i_host.wr(23'(`UNLOCK1_ADDR), `UNLOCK1_DATA, 1'b1);
		i_host.glitch();
		i_host.wr(23'(`UNLOCK2_ADDR), `UNLOCK2_DATA, 1'b1);
		i_host.wr(23'(`UNLOCK1_ADDR), `CMD_PROGRAM, 1'b1);
		i_host.wr(23'h3, 16'h1111, 1'b1);
		idle();
		chk(16'(n_we - w0), 16'h0001);
		chk(last_d, 16'h1111);
		rst_n = 1'b0;
		i_host.hold();
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		prog(23'h0, 23'h3, 16'h1111, `CMD_PROGRAM, 1'b1);
		none();
		prog(23'h0, 23'h3, 16'h2222, `CMD_PROGRAM, 1'b1);
		idle();
		chk(last_d, 16'h2222);
		$display("refusal tests done");
		finish_test();
	end
endmodule
